// ==== hw/asi_core.sv ====
// Purpose: async serial interface data path, transmit and receive
// Assumes: inputs synchronous to clk; 16x tick from TICK_DIV
// Notes:   PIO full duplex, DMA one direction at a time
//
// Summary of operation
// - transmit adds start, stop, optional parity
// - missing stop bit flags framing error
// - unread character overwritten flags overrun
// - sixteen-bit word holds bytes to send
// - transmit words accepted without any reset
// - PIO transmit completion sets the flag
// - DMA transmit completion requests memory instead
// - received character loads buffer, PIO sets flag
// - DMA receive requests memory write cycle
// - receiver and transmitter enabled independently
// - DMA runs one direction only
// - status or control readable on bus
// - data registers and control on internal bus
// - input strobe drives data input register
// - PIO sends low byte of output word
// - DMA sends upper byte then lower
// - byte select names next byte sent
// - byte moves only when transmitter empty
// - echo loops receive line to transmitter
// - receive line fans to break detect
// - frame: start, LSB first, 7/8 bits
// - line idles at mark level
// - engines run at sixteen times bit rate
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
module asi_core #(
  parameter int TICK_DIV = 16
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  input  wire logic        rxSerial,
  output logic             txSerial,
  output logic             breakLine,
  input  wire logic        memGrant,
  input  wire logic [15:0] memRdData,
  output logic             memReq,
  output logic      [15:0] memWrData,
  output logic             inputDriveStrobe,
  output logic             byteHalfSelect,
  output logic             flag
);
  localparam int DW = $clog2(TICK_DIV + 1);

  function automatic logic parity_of(input logic [7:0] d,
                                     input logic odd);
    parity_of = (^d) ^ odd;
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  asi_pkg::asi_control_s ctrl_ff;
  asi_pkg::asi_status_s  stat;
  asi_pkg::asi_line_e    txSt_ff, rxSt_ff;
  logic [15:0] dataOut_ff, dataIn_ff, dmaCnt_ff, regRdData_ff;
  logic [DW-1:0] divCnt_ff;
  logic        tick_ff;
  logic        rxIn_ff, txLine_ff, txSerial_ff, breakLine_ff;
  logic [7:0]  txHold_ff, txShift_ff, rxShift_ff;
  logic        txHoldFull_ff, setPend_ff, wordValid_ff;
  logic        byteHalf_ff, memReq_ff, strobe_ff, flag_ff;
  logic        rxFull_ff, frErr_ff, ovErr_ff, parErr_ff;
  logic        txDoneSt_ff, rxDoneSt_ff;
  logic [3:0]  txTick_ff, rxTick_ff;
  logic [2:0]  txBit_ff, rxBit_ff;
  logic        txStop2_ff, rxParBad_ff;
  logic        txDone, rxChar, frEvt, parEvt;
  logic        holdLoad, dmaDone, grant;
  logic [7:0]  holdByte, rxData;
  logic [2:0]  lastBit;
  logic        txAct, rxAct, txDma, rxDma, wrCmd;

  assign lastBit = ctrl_ff.eightBits ? asi_pkg::BITS_EIGHT
                                     : asi_pkg::BITS_SEVEN;
  assign txAct = ctrl_ff.txEn & ~(ctrl_ff.dmaEn & ctrl_ff.dmaRx);
  assign rxAct = ctrl_ff.rxEn & ~(ctrl_ff.dmaEn & ~ctrl_ff.dmaRx);
  assign txDma = txAct & ctrl_ff.dmaEn;
  assign rxDma = rxAct & ctrl_ff.dmaEn;
  assign wrCmd = regWr & (regAddr == asi_pkg::REG_COMMAND);
  assign grant = memGrant & memReq_ff;

  // ----------------------------------------------------------------
  // 16x bit-rate tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divCnt_ff <= '0;
      tick_ff   <= 1'b0;
    end else if (divCnt_ff == DW'(TICK_DIV - 1)) begin
      divCnt_ff <= '0;
      tick_ff   <= 1'b1;
    end else begin
      divCnt_ff <= divCnt_ff + 1'b1;
      tick_ff   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // line pins, echo and break fan-out
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxIn_ff      <= 1'b1;
      txSerial_ff  <= 1'b1;
      breakLine_ff <= 1'b1;
    end else begin
      rxIn_ff      <= rxSerial;
      txSerial_ff  <= ctrl_ff.echo ? rxIn_ff : txLine_ff;
      breakLine_ff <= rxIn_ff;
    end
  end

  // ----------------------------------------------------------------
  // byte selection into the transmitter holding register
  // ----------------------------------------------------------------
  always_comb begin
    holdByte = byteHalf_ff ? dataOut_ff[7:0] : dataOut_ff[15:8];
    holdLoad = 1'b0;
    if (!txHoldFull_ff && txAct) begin
      if (txDma)
        holdLoad = wordValid_ff;
      else
        holdLoad = setPend_ff;
    end
  end

  // ----------------------------------------------------------------
  // output word, DMA sequencing, counts
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dataOut_ff   <= asi_pkg::WORD_ZERO;
      dmaCnt_ff    <= asi_pkg::WORD_ZERO;
      setPend_ff   <= 1'b0;
      wordValid_ff <= 1'b0;
      byteHalf_ff  <= 1'b1;
      memReq_ff    <= 1'b0;
      strobe_ff    <= 1'b0;
      dmaDone      <= 1'b0;
    end else begin
      strobe_ff <= (regRd & (regAddr == asi_pkg::REG_DATA_IN))
                 | (grant & rxDma);
      dmaDone   <= 1'b0;
      if (regWr && regAddr == asi_pkg::REG_DATA_OUT)
        dataOut_ff <= regWrData;
      if (regWr && regAddr == asi_pkg::REG_DMA_CNT)
        dmaCnt_ff <= regWrData;
      if (wrCmd && regWrData[asi_pkg::CMD_SET_CTRL])
        setPend_ff <= 1'b1;
      else if (holdLoad && !txDma)
        setPend_ff <= 1'b0;
      if (!ctrl_ff.dmaEn)
        byteHalf_ff <= 1'b1;
      if (grant) begin
        memReq_ff <= 1'b0;
        dmaCnt_ff <= dmaCnt_ff - asi_pkg::CNT_ONE;
        dmaDone   <= (dmaCnt_ff == asi_pkg::CNT_ONE);
        if (txDma) begin
          dataOut_ff   <= memRdData;
          wordValid_ff <= 1'b1;
          byteHalf_ff  <= 1'b0;
        end
      end else if (txDma && !wordValid_ff && !txHoldFull_ff &&
                   txSt_ff == asi_pkg::LS_IDLE &&
                   dmaCnt_ff != asi_pkg::WORD_ZERO) begin
        memReq_ff <= 1'b1;
      end else if (rxDma && rxFull_ff &&
                   dmaCnt_ff != asi_pkg::WORD_ZERO) begin
        memReq_ff <= 1'b1;
      end
      if (holdLoad && txDma) begin
        if (!byteHalf_ff)
          byteHalf_ff <= 1'b1;
        else
          wordValid_ff <= 1'b0;
      end
      if (!txDma)
        wordValid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txSt_ff       <= asi_pkg::LS_IDLE;
      txHold_ff     <= asi_pkg::BYTE_ZERO;
      txShift_ff    <= asi_pkg::BYTE_ZERO;
      txHoldFull_ff <= 1'b0;
      txLine_ff     <= 1'b1;
      txTick_ff     <= asi_pkg::TICK_ZERO;
      txBit_ff      <= asi_pkg::CNT3_ZERO;
      txStop2_ff    <= 1'b0;
      txDone        <= 1'b0;
    end else begin
      txDone <= 1'b0;
      if (holdLoad) begin
        txHold_ff     <= holdByte;
        txHoldFull_ff <= 1'b1;
      end
      if (tick_ff) begin
        txTick_ff <= txTick_ff + 1'b1;
        case (txSt_ff)
          asi_pkg::LS_IDLE: begin
            txLine_ff <= 1'b1;
            txTick_ff <= asi_pkg::TICK_ZERO;
            if (txHoldFull_ff) begin
              txShift_ff    <= txHold_ff;
              txHoldFull_ff <= 1'b0;
              txLine_ff     <= 1'b0;
              txSt_ff       <= asi_pkg::LS_START;
            end
          end
          asi_pkg::LS_START: begin
            if (txTick_ff == asi_pkg::TICK_LAST) begin
              txLine_ff <= txShift_ff[0];
              txBit_ff  <= asi_pkg::CNT3_ZERO;
              txSt_ff   <= asi_pkg::LS_DATA;
            end
          end
          asi_pkg::LS_DATA: begin
            if (txTick_ff == asi_pkg::TICK_LAST) begin
              txBit_ff <= txBit_ff + 1'b1;
              if (txBit_ff == lastBit) begin
                txStop2_ff <= 1'b0;
                if (ctrl_ff.parityEn) begin
                  txLine_ff <= parity_of(txShift_ff & (ctrl_ff.eightBits
                               ? 8'hff : 8'h7f), ctrl_ff.parityOdd);
                  txSt_ff   <= asi_pkg::LS_PAR;
                end else begin
                  txLine_ff <= 1'b1;
                  txSt_ff   <= asi_pkg::LS_STOP;
                end
              end else begin
                txLine_ff <= txShift_ff[txBit_ff + 3'h1];
              end
            end
          end
          asi_pkg::LS_PAR: begin
            if (txTick_ff == asi_pkg::TICK_LAST) begin
              txLine_ff <= 1'b1;
              txSt_ff   <= asi_pkg::LS_STOP;
            end
          end
          asi_pkg::LS_STOP: begin
            if (txTick_ff == asi_pkg::TICK_LAST) begin
              if (ctrl_ff.twoStop && !txStop2_ff) begin
                txStop2_ff <= 1'b1;
              end else begin
                txSt_ff <= asi_pkg::LS_IDLE;
                txDone  <= 1'b1;
              end
            end
          end
          default: txSt_ff <= asi_pkg::LS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  assign rxData = ctrl_ff.eightBits ? rxShift_ff
                                    : {1'b0, rxShift_ff[7:1]};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxSt_ff     <= asi_pkg::LS_IDLE;
      rxShift_ff  <= asi_pkg::BYTE_ZERO;
      rxTick_ff   <= asi_pkg::TICK_ZERO;
      rxBit_ff    <= asi_pkg::CNT3_ZERO;
      rxParBad_ff <= 1'b0;
      rxChar      <= 1'b0;
      frEvt       <= 1'b0;
      parEvt      <= 1'b0;
    end else begin
      rxChar <= 1'b0;
      frEvt  <= 1'b0;
      parEvt <= 1'b0;
      if (tick_ff) begin
        rxTick_ff <= rxTick_ff + 1'b1;
        case (rxSt_ff)
          asi_pkg::LS_IDLE: begin
            rxTick_ff <= asi_pkg::TICK_ZERO;
            if (rxAct && !rxIn_ff)
              rxSt_ff <= asi_pkg::LS_START;
          end
          asi_pkg::LS_START: begin
            if (rxTick_ff == asi_pkg::TICK_MID) begin
              rxTick_ff <= asi_pkg::TICK_ZERO;
              rxBit_ff  <= asi_pkg::CNT3_ZERO;
              rxSt_ff   <= rxIn_ff ? asi_pkg::LS_IDLE
                                   : asi_pkg::LS_DATA;
            end
          end
          asi_pkg::LS_DATA: begin
            if (rxTick_ff == asi_pkg::TICK_LAST) begin
              rxShift_ff <= {rxIn_ff, rxShift_ff[7:1]};
              rxBit_ff   <= rxBit_ff + 1'b1;
              if (rxBit_ff == lastBit)
                rxSt_ff <= ctrl_ff.parityEn ? asi_pkg::LS_PAR
                                            : asi_pkg::LS_STOP;
            end
          end
          asi_pkg::LS_PAR: begin
            if (rxTick_ff == asi_pkg::TICK_LAST) begin
              rxParBad_ff <= rxIn_ff !=
                             parity_of(rxData, ctrl_ff.parityOdd);
              rxSt_ff     <= asi_pkg::LS_STOP;
            end
          end
          asi_pkg::LS_STOP: begin
            if (rxTick_ff == asi_pkg::TICK_LAST) begin
              rxChar      <= 1'b1;
              frEvt       <= ~rxIn_ff;
              parEvt      <= ctrl_ff.parityEn & rxParBad_ff;
              rxParBad_ff <= 1'b0;
              rxSt_ff     <= asi_pkg::LS_IDLE;
            end
          end
          default: rxSt_ff <= asi_pkg::LS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // input buffer, errors and flag (set wins over clear)
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dataIn_ff   <= asi_pkg::WORD_ZERO;
      rxFull_ff   <= 1'b0;
      frErr_ff    <= 1'b0;
      ovErr_ff    <= 1'b0;
      parErr_ff   <= 1'b0;
      txDoneSt_ff <= 1'b0;
      rxDoneSt_ff <= 1'b0;
      flag_ff     <= 1'b0;
    end else begin
      if ((regRd && regAddr == asi_pkg::REG_DATA_IN) || (grant && rxDma))
        rxFull_ff <= 1'b0;
      if (wrCmd && regWrData[asi_pkg::CMD_CLR_ERR]) begin
        frErr_ff  <= 1'b0;
        ovErr_ff  <= 1'b0;
        parErr_ff <= 1'b0;
      end
      if (wrCmd && regWrData[asi_pkg::CMD_CLR_FLAG]) begin
        flag_ff     <= 1'b0;
        txDoneSt_ff <= 1'b0;
        rxDoneSt_ff <= 1'b0;
      end
      if (rxChar) begin
        dataIn_ff <= {asi_pkg::BYTE_ZERO, rxData};
        rxFull_ff <= 1'b1;
        if (rxFull_ff)
          ovErr_ff <= 1'b1;
      end
      if (frEvt)
        frErr_ff <= 1'b1;
      if (parEvt)
        parErr_ff <= 1'b1;
      if (txDone && !txDma) begin
        txDoneSt_ff <= 1'b1;
        flag_ff     <= 1'b1;
      end
      if (rxChar && !rxDma) begin
        rxDoneSt_ff <= 1'b1;
        flag_ff     <= 1'b1;
      end
      if (frEvt || parEvt || (rxChar && rxFull_ff) || dmaDone)
        flag_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control register and read selector
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      ctrl_ff <= '0;
    else if (regWr && regAddr == asi_pkg::REG_CONTROL)
      ctrl_ff <= regWrData;
  end

  always_comb begin
    stat            = '0;
    stat.flag       = flag_ff;
    stat.txRegEmpty = ~txHoldFull_ff;
    stat.rxFull     = rxFull_ff;
    stat.framingErr = frErr_ff;
    stat.overrunErr = ovErr_ff;
    stat.parityErr  = parErr_ff;
    stat.txDone     = txDoneSt_ff;
    stat.rxDone     = rxDoneSt_ff;
    stat.dmaBusy    = ctrl_ff.dmaEn & (dmaCnt_ff != asi_pkg::WORD_ZERO);
    stat.lineLevel  = rxIn_ff;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData_ff <= asi_pkg::WORD_ZERO;
    end else if (regRd) begin
      case (regAddr)
        asi_pkg::REG_CONTROL: regRdData_ff <= ctrl_ff;
        asi_pkg::REG_STATUS:  regRdData_ff <= stat;
        asi_pkg::REG_DATA_IN: regRdData_ff <= dataIn_ff;
        asi_pkg::REG_DMA_CNT: regRdData_ff <= dmaCnt_ff;
        default:              regRdData_ff <= asi_pkg::WORD_ZERO;
      endcase
    end else begin
      regRdData_ff <= asi_pkg::WORD_ZERO;
    end
  end

  assign regRdData        = regRdData_ff;
  assign txSerial         = txSerial_ff;
  assign breakLine        = breakLine_ff;
  assign memReq           = memReq_ff;
  assign memWrData        = dataIn_ff;
  assign inputDriveStrobe = strobe_ff;
  assign byteHalfSelect   = byteHalf_ff;
  assign flag             = flag_ff;
endmodule

// ==== hw/asi_pkg.sv ====
// Purpose: constants and types for the async serial host interface
// Assumes: one clock, 16x bit-rate tick made by a divider
// Notes:   register indices on the plain register port
package asi_pkg;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_DATA_OUT = 3'h0;
  localparam logic [2:0] REG_CONTROL  = 3'h1;
  localparam logic [2:0] REG_STATUS   = 3'h2;
  localparam logic [2:0] REG_DATA_IN  = 3'h3;
  localparam logic [2:0] REG_COMMAND  = 3'h4;
  localparam logic [2:0] REG_DMA_CNT  = 3'h5;
  // ----------------------------------------------------------------
  // command bits
  // ----------------------------------------------------------------
  localparam int CMD_SET_CTRL  = 0;
  localparam int CMD_CLR_FLAG  = 1;
  localparam int CMD_CLR_ERR   = 2;
  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_ZERO    = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [3:0]  TICK_LAST    = 4'hf;
  localparam logic [3:0]  TICK_MID     = 4'h7;
  localparam logic [3:0]  TICK_ZERO    = 4'h0;
  localparam logic [2:0]  BITS_SEVEN   = 3'h6;
  localparam logic [2:0]  BITS_EIGHT   = 3'h7;
  localparam logic [2:0]  CNT3_ZERO    = 3'h0;
  localparam logic [15:0] CNT_ONE      = 16'h0001;

  typedef struct packed {
    logic [6:0] spare;
    logic       twoStop;
    logic       eightBits;
    logic       parityOdd;
    logic       parityEn;
    logic       echo;
    logic       dmaRx;
    logic       dmaEn;
    logic       rxEn;
    logic       txEn;
  } asi_control_s;

  typedef struct packed {
    logic [5:0] spare;
    logic       lineLevel;
    logic       dmaBusy;
    logic       rxDone;
    logic       txDone;
    logic       parityErr;
    logic       overrunErr;
    logic       framingErr;
    logic       rxFull;
    logic       txRegEmpty;
    logic       flag;
  } asi_status_s;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b000,
    LS_START = 3'b001,
    LS_DATA  = 3'b011,
    LS_PAR   = 3'b010,
    LS_STOP  = 3'b110
  } asi_line_e;
endpackage

// ==== tb/asi_core_monitor.sv ====
// Purpose: port checker for the serial interface core
// Assumes: one clock domain, reset async high
// Notes:   attached by bind
`timescale 1ns/100ps
module asi_core_monitor #(
  parameter int TICK_DIV = 16
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [2:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  input wire logic        rxSerial,
  input wire logic        txSerial,
  input wire logic        breakLine,
  input wire logic        memGrant,
  input wire logic [15:0] memRdData,
  input wire logic        memReq,
  input wire logic [15:0] memWrData,
  input wire logic        inputDriveStrobe,
  input wire logic        byteHalfSelect,
  input wire logic        flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_RD_IDLE_ZERO: assert property (!$past(regRd) |->
    regRdData == 16'h0000)
    else $error("read data not zero outside read cycle");
  AST_BREAK_COPY: assert property (breakLine == $past(rxSerial, 2))
    else $error("break line not a copy of receive line");
  AST_GRANT_DROP: assert property (memReq && memGrant |=> !memReq)
    else $error("memory request kept after grant");
  AST_REQ_HOLD: assert property (memReq && !memGrant |=> memReq)
    else $error("memory request dropped before grant");
  AST_STROBE_CAUSE: assert property (inputDriveStrobe |->
    $past(regRd && regAddr == asi_pkg::REG_DATA_IN) ||
    $past(memReq && memGrant))
    else $error("input strobe without read or grant");
  AST_FLAG_CLEAR: assert property ($fell(flag) |-> $past(regWr &&
    regAddr == asi_pkg::REG_COMMAND && regWrData[asi_pkg::CMD_CLR_FLAG]))
    else $error("flag fell without clear command");
  AST_OUT_READ_ZERO: assert property (regRd &&
    regAddr == asi_pkg::REG_DATA_OUT |=> regRdData == 16'h0000)
    else $error("data out register read not zero");
  AST_CTRL_BACK: assert property (regRd &&
    regAddr == asi_pkg::REG_CONTROL &&
    $past(regWr && regAddr == asi_pkg::REG_CONTROL, 2) |=>
    regRdData[8:0] == $past(regWrData[8:0], 3))
    else $error("control readback differs from write");
endmodule
bind asi_core asi_core_monitor #(.TICK_DIV(TICK_DIV)) asi_core_monitor_i (
  .clk, .reset, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .rxSerial,
  .txSerial, .breakLine, .memGrant, .memRdData, .memReq, .memWrData,
  .inputDriveStrobe, .byteHalfSelect, .flag);

// ==== tb/asi_mem_model.sv ====
// Purpose: memory side of the dma channel, grants requests
// Assumes: memReq held until granted
// Notes:   first grant slow, then prompt and slow by turns
`timescale 1ns/100ps
module asi_mem_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        memReq,
  input  wire logic [15:0] memWord,
  output logic             memGrant,
  output logic      [15:0] memRdData
);
  logic [2:0] waitCnt_ff;
  logic       slow_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      memGrant   <= 1'b0;
      memRdData  <= 16'h0000;
      waitCnt_ff <= 3'h4;
      slow_ff    <= 1'b0;
    end else begin
      memGrant  <= 1'b0;
      memRdData <= ~memRdData;
      if (memReq && !memGrant) begin
        if (waitCnt_ff == 3'h0) begin
          memGrant   <= 1'b1;
          memRdData  <= memWord;
          waitCnt_ff <= slow_ff ? 3'h5 : 3'h0;
          slow_ff    <= ~slow_ff;
        end else
          waitCnt_ff <= waitCnt_ff - 3'h1;
      end
    end
  end
endmodule

// ==== tb/test_async_serial_host_interface.sv ====
// Purpose: self-checking bench for the serial interface core
// Assumes: short tick divider, bit time BT clocks
// Notes:   expected frames built from a byte queue
`timescale 1ns/100ps
module test_async_serial_host_interface;
  localparam int TD = 2;
  localparam int BT = 16 * TD;
  logic        clk, reset, regWr, regRd, rxSerial, memGrant, txSerial;
  logic        breakLine, memReq, inputDriveStrobe, byteHalfSelect, flag;
  logic [2:0]  regAddr;
  logic [15:0] regWrData, regRdData, memRdData, memWrData, memWord, v, w;
  logic [10:0] f;
  logic [7:0]  c;
  logic [31:0] seed;
  logic [7:0]  expq[$];
  logic [15:0] modes[3] = '{16'h00a1, 16'h0061, 16'h0081};
  int          error_cnt, comparisons;
  // ----------------------------------------------------------------
  // design, memory model, clock
  // ----------------------------------------------------------------
  asi_core #(.TICK_DIV(TD)) asi_core_i (.clk, .reset, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .rxSerial, .txSerial, .breakLine, .memGrant,
    .memRdData, .memReq, .memWrData, .inputDriveStrobe, .byteHalfSelect,
    .flag);
  asi_mem_model asi_mem_model_i (.clk, .reset, .memReq, .memWord,
    .memGrant, .memRdData);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic int flen(input logic [15:0] ctl);
    return (ctl[7] ? 10 : 9) + int'(ctl[5]);
  endfunction
  function automatic logic [10:0] frm(input logic [7:0] b,
                                      input logic [15:0] ctl);
    logic [10:0] r;
    r = '1;
    b[7] = b[7] & ctl[7];
    r[0] = 1'b0;
    r[8:1] = b;
    if (!ctl[7]) r[8] = 1'b1;
    if (ctl[5]) r[flen(ctl) - 2] = ctl[6] ^ (^b);
    return r;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask
  task automatic rst();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
  endtask
  task automatic wflag();
    for (int k = 0; k < 4 * BT && flag !== 1'b1; k++) @(negedge clk);
  endtask
  // captures one frame at mid-bit and compares with the queued byte
  task automatic txc(input logic [15:0] ctl);
    f = '1;
    for (int k = 0; k < 40 * BT && txSerial !== 1'b0; k++) @(negedge clk);
    repeat (BT / 2) @(negedge clk);
    for (int i = 0; i < flen(ctl); i++) begin
      f[i] = txSerial;
      if (i + 1 < flen(ctl)) repeat (BT) @(negedge clk);
    end
    chk({5'h00, f}, {5'h00, frm(expq.pop_front(), ctl)});
  endtask
  task automatic rxs(input logic [7:0] b, input logic [15:0] ctl,
                     input logic stp);
    logic [10:0] r;
    r = frm(b, ctl);
    r[flen(ctl) - 1] = stp;
    for (int i = 0; i < flen(ctl); i++) begin
      @(posedge clk);
      rxSerial <= r[i];
      repeat (BT - 1) @(posedge clk);
    end
    @(posedge clk);
    rxSerial <= 1'b1;
    repeat (2 * BT) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 3'h0;
    regWrData = 16'h0000;
    rxSerial = 1'b1;
    memWord = 16'h0000;
    seed = 32'h0000_0018;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk({14'h0000, txSerial, breakLine}, 16'h0003);
    chk({14'h0000, flag, byteHalfSelect}, 16'h0001);
    v = rnd();
    wr(asi_pkg::REG_CONTROL, v);
    rd(asi_pkg::REG_CONTROL, w);
    chk(w & 16'h01ff, v & 16'h01ff);
    rd(3'h7, w);
    chk(w, 16'h0000);
    rd(asi_pkg::REG_DATA_OUT, w);
    chk(w, 16'h0000);
    rst();
    foreach (modes[m]) begin
      v = rnd();
      expq.push_back(v[7:0]);
      wr(asi_pkg::REG_CONTROL, modes[m]);
      wr(asi_pkg::REG_DATA_OUT, v);
      wr(asi_pkg::REG_COMMAND, 16'h0001);
      txc(modes[m]);
      wflag();
      rd(asi_pkg::REG_STATUS, v);
      chk(v & 16'h0041, 16'h0041);
      wr(asi_pkg::REG_COMMAND, 16'h0002);
    end
    wr(asi_pkg::REG_CONTROL, 16'h00a3);
    v = rnd();
    rxs(v[7:0], 16'h00a2, 1'b1);
    rd(asi_pkg::REG_STATUS, w);
    chk(w & 16'h003d, 16'h0005);
    rd(asi_pkg::REG_DATA_IN, w);
    chk(w, {8'h00, v[7:0]});
    chk({15'h0000, inputDriveStrobe}, 16'h0001);
    c = v[15:8];
    rxs(v[7:0], 16'h00a2, 1'b1);
    rxs(c, 16'h00a2, 1'b1);
    rd(asi_pkg::REG_STATUS, w);
    chk(w & 16'h0010, 16'h0010);
    rd(asi_pkg::REG_DATA_IN, w);
    chk(w, {8'h00, c});
    wr(asi_pkg::REG_COMMAND, 16'h0006);
    rxs(c, 16'h00a2, 1'b0);
    rd(asi_pkg::REG_STATUS, w);
    chk(w & 16'h0008, 16'h0008);
    wr(asi_pkg::REG_CONTROL, 16'h0010);
    rxSerial <= 1'b0;
    repeat (3) @(negedge clk);
    chk({14'h0000, txSerial, breakLine}, 16'h0000);
    @(posedge clk);
    rxSerial <= 1'b1;
    rst();
    wr(asi_pkg::REG_DMA_CNT, 16'h0001);
    wr(asi_pkg::REG_CONTROL, 16'h008e);
    v = rnd();
    rxs(v[7:0], 16'h008e, 1'b1);
    chk(memWrData, {8'h00, v[7:0]});
    chk({15'h0000, flag}, 16'h0001);
    rst();
    memWord = rnd();
    expq.push_back(memWord[15:8]);
    expq.push_back(memWord[7:0]);
    wr(asi_pkg::REG_DMA_CNT, 16'h0001);
    wr(asi_pkg::REG_CONTROL, 16'h00a5);
    txc(16'h00a5);
    txc(16'h00a5);
    chk({15'h0000, flag}, 16'h0001);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule
